/* File: core/slss_top.sv */
`timescale 1ns/1ns
// Function
// - Control code 0x01 in sync control selects one-shot multiframe alignment.
// - Host writes enable then arm; waiting for reference starts only when armed.
// - Aligned sync machine reports lock in sync status bit 3.
// - Serial PLL status bit 0 reads one when PLL is enabled and locked.
// - Logical lanes with invert bit set have their data inverted.
// - Four crossbar registers map physical lanes onto logical lanes.
// - Link enable three with two links enables both; one with a single link enables link zero.
// - Subclass zero needs no reference; subclass one needs aligned reference.
// - Two links operate independently, each with its own reset.
module slss_top #(
  parameter int WIDTH = 8,
  parameter int NLANES = 8
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Register port
  input wire slss_pkg::slss_req_s req,
  output logic [7:0] rdata,
  output logic rvalid,
  // Reference and PLL
  input wire logic sysref_in,
  input wire logic serial_pll_enable,
  input wire logic serial_pll_locked,
  // Per-link resets, active low
  input wire logic link0_rst_n,
  input wire logic link1_rst_n,
  // Lane data
  input wire logic [NLANES*WIDTH-1:0] phys_data,
  output logic [NLANES*WIDTH-1:0] logical_data,
  // Link state
  output logic [1:0] link_active,
  output logic lmfc_align
);
  import slss_pkg::*;

  // =====================================
  // Synchronisers
  logic [2:0] ref_sync_reg, ref_sync_next;
  logic [1:0] pll_sync_reg, pll_sync_next;
  logic [1:0] en_sync_reg, en_sync_next;
  always_comb begin
    ref_sync_next = {ref_sync_reg[1:0], sysref_in};
    pll_sync_next = {pll_sync_reg[0], serial_pll_locked};
    en_sync_next = {en_sync_reg[0], serial_pll_enable};
    if (!reset_n) begin
      ref_sync_next = '0;
      pll_sync_next = '0;
      en_sync_next = '0;
    end
  end
  always_ff @(posedge sys_clk) begin
    ref_sync_reg <= ref_sync_next;
    pll_sync_reg <= pll_sync_next;
    en_sync_reg <= en_sync_next;
  end
  logic ref_rise;
  assign ref_rise = ref_sync_reg[1] & ~ref_sync_reg[2];

  // =====================================
  // Registers
  logic [7:0] sync_ctl_reg, sync_ctl_next;
  logic [7:0] link_ctl_reg, link_ctl_next;
  logic [7:0] subclass_reg, subclass_next;
  logic [7:0] dly_a_reg, dly_a_next, dly_b_reg, dly_b_next;
  logic [7:0] win_a_reg, win_a_next, win_b_reg, win_b_next;
  logic [31:0] map_reg, map_next;
  logic [7:0] inv_reg, inv_next;
  logic [7:0] rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next;
  logic sync_lock;
  logic pll_ok;
  assign pll_ok = pll_sync_reg[1] & en_sync_reg[1];

  always_comb begin
    sync_ctl_next = sync_ctl_reg;
    link_ctl_next = link_ctl_reg;
    subclass_next = subclass_reg;
    dly_a_next = dly_a_reg;
    dly_b_next = dly_b_reg;
    win_a_next = win_a_reg;
    win_b_next = win_b_reg;
    map_next = map_reg;
    inv_next = inv_reg;
    rdata_next = rdata_reg;
    rvalid_next = req.rd;
    if (req.wr) begin
      unique case (req.addr)
        OFS_SYNC_CONTROL: sync_ctl_next = req.wdata;
        OFS_LINK_CONTROL: link_ctl_next = req.wdata;
        OFS_LINK_SUBCLASS: subclass_next = req.wdata;
        OFS_MF_DELAY_A: dly_a_next = req.wdata;
        OFS_MF_DELAY_B: dly_b_next = req.wdata;
        OFS_MF_WINDOW_A: win_a_next = req.wdata;
        OFS_MF_WINDOW_B: win_b_next = req.wdata;
        OFS_LANE_POLARITY_INVERT: inv_next = req.wdata;
        default: begin
          if (req.addr >= OFS_LANE_MAP_0 && req.addr <= OFS_LANE_MAP_3) begin
            map_next[2'(req.addr - OFS_LANE_MAP_0)*8 +: 8] = req.wdata;
          end
        end
      endcase
    end
    if (req.rd) begin
      unique case (req.addr)
        OFS_SYNC_CONTROL: rdata_next = sync_ctl_reg;
        OFS_SYNC_STATUS: rdata_next = 8'(sync_lock) << SYNC_LOCK_BIT;
        OFS_SERIAL_PLL_STATUS: rdata_next = 8'(pll_ok) << PLL_LOCK_BIT;
        OFS_LINK_CONTROL: rdata_next = link_ctl_reg;
        OFS_LINK_SUBCLASS: rdata_next = subclass_reg;
        OFS_MF_DELAY_A: rdata_next = dly_a_reg;
        OFS_MF_DELAY_B: rdata_next = dly_b_reg;
        OFS_MF_WINDOW_A: rdata_next = win_a_reg;
        OFS_MF_WINDOW_B: rdata_next = win_b_reg;
        OFS_LANE_POLARITY_INVERT: rdata_next = inv_reg;
        default: begin
          rdata_next = RESET_BYTE;
          if (req.addr >= OFS_LANE_MAP_0 && req.addr <= OFS_LANE_MAP_3) begin
            rdata_next = map_reg[2'(req.addr - OFS_LANE_MAP_0)*8 +: 8];
          end
        end
      endcase
    end
    if (!reset_n) begin
      sync_ctl_next = RESET_BYTE;
      link_ctl_next = RESET_BYTE;
      subclass_next = RESET_BYTE;
      dly_a_next = RESET_BYTE;
      dly_b_next = RESET_BYTE;
      win_a_next = RESET_BYTE;
      win_b_next = RESET_BYTE;
      map_next = 32'h00000000;
      inv_next = RESET_BYTE;
      rdata_next = RESET_BYTE;
      rvalid_next = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    sync_ctl_reg <= sync_ctl_next;
    link_ctl_reg <= link_ctl_next;
    subclass_reg <= subclass_next;
    dly_a_reg <= dly_a_next;
    dly_b_reg <= dly_b_next;
    win_a_reg <= win_a_next;
    win_b_reg <= win_b_next;
    map_reg <= map_next;
    inv_reg <= inv_next;
    rdata_reg <= rdata_next;
    rvalid_reg <= rvalid_next;
  end
  assign rdata = rdata_reg;
  assign rvalid = rvalid_reg;

  // =====================================
  // One-shot sync machine
  slss_sync_e st_reg, st_next;
  logic align_reg, align_next;
  logic ctl_wr;
  assign ctl_wr = req.wr && (req.addr == OFS_SYNC_CONTROL);
  always_comb begin
    st_next = st_reg;
    align_next = 1'b0;
    unique case (st_reg)
      SYNC_IDLE: begin
        if (ctl_wr && req.wdata == SYNC_CODE_ENABLE) begin
          st_next = SYNC_ENABLED;
        end
      end
      SYNC_ENABLED: begin
        if (ctl_wr && req.wdata == SYNC_CODE_ARM) begin
          st_next = SYNC_ARMED;
        end
      end
      SYNC_ARMED: begin
        if (subclass_reg != SUBCLASS_ONE) begin
          st_next = SYNC_LOCKED;
          align_next = 1'b1;
        end else if (ref_rise) begin
          st_next = SYNC_LOCKED;
          align_next = 1'b1;
        end
      end
      SYNC_LOCKED: begin
        if (ctl_wr && req.wdata == SYNC_CODE_ARM) begin
          st_next = SYNC_ARMED;
        end
      end
    endcase
    if (ctl_wr && req.wdata == SYNC_MODE_ONE_SHOT) begin
      st_next = SYNC_IDLE;
    end
    if (!reset_n) begin
      st_next = SYNC_IDLE;
      align_next = 1'b0;
    end
  end
  always_ff @(posedge sys_clk) begin
    st_reg <= st_next;
    align_reg <= align_next;
  end
  assign sync_lock = (st_reg == SYNC_LOCKED);
  assign lmfc_align = align_reg;

  // =====================================
  // Link enables
  slss_link_s link_cfg;
  logic [1:0] act_reg, act_next;
  assign link_cfg = '{link_on: link_ctl_reg[1:0], two_link: link_ctl_reg[TWO_LINK_BIT],
                      cfg_sum: link_ctl_reg[CFG_SUM_BIT], subclass: subclass_reg};
  always_comb begin
    act_next = 2'h0;
    if (link_cfg.two_link && link_cfg.link_on == LINKS_BOTH) begin
      act_next = {link1_rst_n, link0_rst_n};
    end else if (!link_cfg.two_link && link_cfg.link_on == LINKS_ZERO) begin
      act_next = {1'b0, link0_rst_n};
    end
    if (!reset_n) begin
      act_next = 2'h0;
    end
  end
  always_ff @(posedge sys_clk) begin
    act_reg <= act_next;
  end
  assign link_active = act_reg;

  // =====================================
  // Crossbar and inversion per logical lane
  for (genvar i = 0; i < NLANES; i++) begin : g_lane
    slss_lane #(.WIDTH(WIDTH), .NLANES(NLANES)) u_lane (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .phys_data(phys_data),
      .sel(map_reg[i*4 +: 3]),
      .invert(inv_reg[i]),
      .lane_out(logical_data[i*WIDTH +: WIDTH])
    );
  end

  // =====================================
  // Checks
  property p_arm_lock;
    @(posedge sys_clk) disable iff (!reset_n)
    (st_reg != SYNC_ARMED) ##1 (st_reg == SYNC_ARMED)
      |-> $past(ctl_wr && req.wdata == SYNC_CODE_ARM);
  endproperty
  a_arm_lock: assert property (p_arm_lock) else $error("lock without arming");
  property p_ref_lock;
    @(posedge sys_clk) disable iff (!reset_n)
    (st_reg == SYNC_ARMED && subclass_reg == SUBCLASS_ONE && ref_rise && !ctl_wr)
      |=> sync_lock && align_reg;
  endproperty
  a_ref_lock: assert property (p_ref_lock) else $error("edge did not lock");
  property p_sub0;
    @(posedge sys_clk) disable iff (!reset_n)
    (st_reg == SYNC_ARMED && subclass_reg != SUBCLASS_ONE && !ctl_wr) |=> sync_lock && align_reg;
  endproperty
  a_sub0: assert property (p_sub0) else $error("subclass zero did not lock");
  property p_lock_stat;
    @(posedge sys_clk) disable iff (!reset_n)
    (req.rd && req.addr == OFS_SYNC_STATUS) |=> rdata[SYNC_LOCK_BIT] == $past(sync_lock);
  endproperty
  a_lock_stat: assert property (p_lock_stat) else $error("lock status wrong");
  property p_one_shot;
    @(posedge sys_clk) disable iff (!reset_n)
    (st_reg == SYNC_LOCKED) |=> !align_reg;
  endproperty
  a_one_shot: assert property (p_one_shot) else $error("realigned after lock");
  property p_mode;
    @(posedge sys_clk) disable iff (!reset_n)
    (ctl_wr && req.wdata == SYNC_MODE_ONE_SHOT) |=> st_reg == SYNC_IDLE;
  endproperty
  a_mode: assert property (p_mode) else $error("mode write ignored");
  property p_pll;
    @(posedge sys_clk) disable iff (!reset_n)
    (req.rd && req.addr == OFS_SERIAL_PLL_STATUS) |=> rdata[PLL_LOCK_BIT] == $past(pll_ok);
  endproperty
  a_pll: assert property (p_pll) else $error("pll status wrong");
  property p_single;
    @(posedge sys_clk) disable iff (!reset_n)
    !link_cfg.two_link |=> !link_active[1];
  endproperty
  a_single: assert property (p_single) else $error("link one on in single mode");
  property p_inv;
    @(posedge sys_clk) disable iff (!reset_n)
    inv_reg[0] |=> logical_data[WIDTH-1:0] == ~$past(phys_data[map_reg[2:0]*WIDTH +: WIDTH]);
  endproperty
  a_inv: assert property (p_inv) else $error("lane zero not inverted");
  property p_map;
    @(posedge sys_clk) disable iff (!reset_n)
    !inv_reg[1] |=> logical_data[2*WIDTH-1:WIDTH] == $past(phys_data[map_reg[6:4]*WIDTH +: WIDTH]);
  endproperty
  a_map: assert property (p_map) else $error("lane one misrouted");
  property p_rst1;
    @(posedge sys_clk) disable iff (!reset_n)
    !link1_rst_n |=> !link_active[1];
  endproperty
  a_rst1: assert property (p_rst1) else $error("link one active in reset");
  c_lock: cover property (@(posedge sys_clk) disable iff (!reset_n) align_reg);
  c_dual: cover property (@(posedge sys_clk) disable iff (!reset_n) link_active == 2'h3);
  c_rearm: cover property (@(posedge sys_clk) disable iff (!reset_n)
    (st_reg == SYNC_LOCKED) ##1 (st_reg == SYNC_ARMED));
  c_sum: cover property (@(posedge sys_clk) disable iff (!reset_n)
    link_cfg.cfg_sum && link_active == 2'h3);
  c_sub0: cover property (@(posedge sys_clk) disable iff (!reset_n)
    sync_lock && link_cfg.subclass == RESET_BYTE);
endmodule

/* File: core/slss_pkg.sv */
package slss_pkg;
  // =====================================
  // Register offsets
  localparam logic [11:0] OFS_SYNC_CONTROL = 12'h03A;
  localparam logic [11:0] OFS_SYNC_STATUS = 12'h03B;
  localparam logic [11:0] OFS_SERIAL_PLL_STATUS = 12'h281;
  localparam logic [11:0] OFS_LINK_CONTROL = 12'h300;
  localparam logic [11:0] OFS_LINK_SUBCLASS = 12'h301;
  localparam logic [11:0] OFS_MF_DELAY_A = 12'h304;
  localparam logic [11:0] OFS_MF_DELAY_B = 12'h305;
  localparam logic [11:0] OFS_MF_WINDOW_A = 12'h306;
  localparam logic [11:0] OFS_MF_WINDOW_B = 12'h307;
  localparam logic [11:0] OFS_LANE_MAP_0 = 12'h308;
  localparam logic [11:0] OFS_LANE_MAP_3 = 12'h30B;
  localparam logic [11:0] OFS_LANE_POLARITY_INVERT = 12'h334;
  // =====================================
  // Field values and positions
  localparam logic [7:0] SYNC_MODE_ONE_SHOT = 8'h01;
  localparam logic [7:0] SYNC_CODE_ENABLE = 8'h81;
  localparam logic [7:0] SYNC_CODE_ARM = 8'hC1;
  localparam int SYNC_LOCK_BIT = 3;
  localparam int PLL_LOCK_BIT = 0;
  localparam int CFG_SUM_BIT = 6;
  localparam int TWO_LINK_BIT = 3;
  localparam logic [1:0] LINKS_BOTH = 2'h3;
  localparam logic [1:0] LINKS_ZERO = 2'h1;
  localparam logic [7:0] SUBCLASS_ONE = 8'h01;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam int NUM_LANES = 8;
  // =====================================
  // Types
  typedef enum logic [1:0] {SYNC_IDLE, SYNC_ENABLED, SYNC_ARMED, SYNC_LOCKED} slss_sync_e;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [7:0] wdata;
  } slss_req_s;
  typedef struct packed {
    logic [1:0] link_on;
    logic two_link;
    logic cfg_sum;
    logic [7:0] subclass;
  } slss_link_s;
endpackage

/* File: core/slss_lane.sv */
`timescale 1ns/1ns
module slss_lane #(
  parameter int WIDTH = 8,
  parameter int NLANES = 8
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Lane data
  input wire logic [NLANES*WIDTH-1:0] phys_data,
  input wire logic [2:0] sel,
  input wire logic invert,
  output logic [WIDTH-1:0] lane_out
);
  import slss_pkg::*;
  logic [WIDTH-1:0] out_reg;
  logic [WIDTH-1:0] out_next;

  // =====================================
  // Select and invert one logical lane
  always_comb begin
    out_next = phys_data[sel*WIDTH +: WIDTH];
    if (invert) begin
      out_next = ~out_next;
    end
    if (!reset_n) begin
      out_next = '0;
    end
  end

  always_ff @(posedge sys_clk) begin
    out_reg <= out_next;
  end

  assign lane_out = out_reg;
endmodule

/* File: tb/slss_far_end.sv */
`timescale 1ns/1ns
// ==============================
// Far-end transmitter and reference source
module slss_far_end (
  // Clock
  input wire logic sys_clk,
  // Bench controls
  input wire logic fire,
  input wire logic pll_on,
  input wire logic [7:0] pattern,
  // Device pins
  output logic sysref_in,
  output logic serial_pll_enable,
  output logic serial_pll_locked,
  output logic [63:0] phys_data
);
  logic [1:0] ref_cnt = 2'h0;
  logic [1:0] lock_cnt = 2'h0;
  initial begin
    sysref_in = 1'b0;
    serial_pll_enable = 1'b0;
    serial_pll_locked = 1'b0;
  end
  // Reference edge only on request, two cycles wide
  always @(posedge sys_clk) begin
    if (fire) ref_cnt <= 2'h2;
    else if (ref_cnt != 2'h0) ref_cnt <= ref_cnt - 2'h1;
    sysref_in <= (ref_cnt != 2'h0);
  end
  // Serial PLL locks a few cycles after enable
  always @(posedge sys_clk) begin
    if (!pll_on) lock_cnt <= 2'h0;
    else if (lock_cnt != 2'h3) lock_cnt <= lock_cnt + 2'h1;
    serial_pll_enable <= pll_on;
    serial_pll_locked <= pll_on && (lock_cnt == 2'h3);
  end
  // Same lane count and octet width as the receiver
  always_comb begin
    for (int j = 0; j < 8; j++) phys_data[j*8 +: 8] = pattern ^ 8'(j * 17);
  end
endmodule

/* File: tb/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
  import slss_pkg::*;
  logic sys_clk, reset_n, rvalid, sysref_in, pll_en, pll_lock, lmfc_align;
  logic link0_rst_n, link1_rst_n, fire, pll_on;
  slss_req_s req;
  logic [7:0] rdata, pattern, v;
  logic [63:0] phys_data, logical_data;
  logic [1:0] link_active;
  int error_cnt, comparisons;
  slss_top dut (.sys_clk(sys_clk), .reset_n(reset_n), .req(req), .rdata(rdata),
    .rvalid(rvalid), .sysref_in(sysref_in), .serial_pll_enable(pll_en),
    .serial_pll_locked(pll_lock), .link0_rst_n(link0_rst_n), .link1_rst_n(link1_rst_n),
    .phys_data(phys_data), .logical_data(logical_data), .link_active(link_active),
    .lmfc_align(lmfc_align));
  slss_far_end far (.sys_clk(sys_clk), .fire(fire), .pll_on(pll_on), .pattern(pattern),
    .sysref_in(sysref_in), .serial_pll_enable(pll_en), .serial_pll_locked(pll_lock),
    .phys_data(phys_data));
  // ==============================
  // Compare and bus tasks
  task chk8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task chk64(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %0t: lanes %h expected %h", $time, got, exp);
    end
  endtask
  task reg_wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    req <= {1'b1, 1'b0, a, d};
    @(posedge sys_clk);
    req <= '0;
  endtask
  task reg_rd(input logic [11:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    req <= {1'b0, 1'b1, a, 8'h00};
    @(posedge sys_clk);
    req <= '0;
    #1;
    chk8({7'h00, rvalid}, 8'h01);
    d = rdata;
  endtask
  task print_verdict;
    $display("Mismatches %0d, comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ==============================
  // Scenarios
  task t_regs;
    logic [11:0] ofs [5] = '{OFS_LINK_SUBCLASS, OFS_MF_DELAY_B, OFS_MF_WINDOW_A,
      OFS_LANE_MAP_3, 12'h123};
    reg_wr(12'h123, 8'hFF);
    reg_wr(OFS_SYNC_STATUS, 8'hFF);
    for (int i = 0; i < 5; i++) begin
      reg_rd(ofs[i], v);
      chk8(v, 8'h00);
    end
    reg_rd(OFS_SYNC_STATUS, v);
    chk8(v[7:0] & 8'h08, 8'h00);
  endtask
  task t_pll;
    @(posedge sys_clk);
    pll_on <= 1'b1;
    repeat (8) @(posedge sys_clk);
    reg_rd(OFS_SERIAL_PLL_STATUS, v);
    chk8(v & 8'h01, 8'h01);
    @(posedge sys_clk);
    pll_on <= 1'b0;
    repeat (8) @(posedge sys_clk);
    reg_rd(OFS_SERIAL_PLL_STATUS, v);
    chk8(v & 8'h01, 8'h00);
  endtask
  task send_ref(input logic [7:0] pulses);
    logic [7:0] n;
    n = 8'h00;
    @(posedge sys_clk);
    fire <= 1'b1;
    @(posedge sys_clk);
    fire <= 1'b0;
    repeat (12) begin
      @(posedge sys_clk);
      #1;
      if (lmfc_align !== 1'b0) n++;
    end
    chk8(n, pulses);
  endtask
  task t_sync1;
    reg_wr(OFS_LINK_SUBCLASS, SUBCLASS_ONE);
    reg_wr(OFS_MF_DELAY_A, 8'h05);
    reg_wr(OFS_MF_WINDOW_A, 8'h0C);
    reg_rd(OFS_MF_WINDOW_A, v);
    chk8(v, 8'h0C);
    reg_wr(OFS_SYNC_CONTROL, SYNC_MODE_ONE_SHOT);
    reg_wr(OFS_SYNC_CONTROL, SYNC_CODE_ENABLE);
    send_ref(8'h00);
    reg_wr(OFS_SYNC_CONTROL, SYNC_CODE_ARM);
    repeat (6) @(posedge sys_clk);
    reg_rd(OFS_SYNC_STATUS, v);
    chk8(v & 8'h08, 8'h00);
    send_ref(8'h01);
    reg_rd(OFS_SYNC_STATUS, v);
    chk8(v & 8'h08, 8'h08);
    send_ref(8'h00);
    reg_wr(OFS_SYNC_CONTROL, SYNC_CODE_ARM);
    send_ref(8'h01);
    reg_wr(OFS_SYNC_CONTROL, SYNC_MODE_ONE_SHOT);
    reg_rd(OFS_SYNC_STATUS, v);
    chk8(v & 8'h08, 8'h00);
  endtask
  task t_sync0;
    reg_wr(OFS_LINK_SUBCLASS, 8'h00);
    reg_wr(OFS_SYNC_CONTROL, SYNC_CODE_ENABLE);
    reg_wr(OFS_SYNC_CONTROL, SYNC_CODE_ARM);
    repeat (3) @(posedge sys_clk);
    reg_rd(OFS_SYNC_STATUS, v);
    chk8(v & 8'h08, 8'h08);
  endtask
  task t_lanes;
    logic [63:0] exp;
    logic [7:0] w;
    int p;
    reg_wr(OFS_LANE_MAP_0, 8'h67);
    reg_wr(OFS_LANE_MAP_0 + 12'h1, 8'h45);
    reg_wr(OFS_LANE_MAP_0 + 12'h2, 8'h23);
    reg_wr(OFS_LANE_MAP_3, 8'h89);
    reg_wr(OFS_LANE_POLARITY_INVERT, 8'hA5);
    for (int k = 0; k < 2; k++) begin
      @(posedge sys_clk);
      pattern <= (k == 0) ? 8'h3C : 8'hF0;
      repeat (3) @(posedge sys_clk);
      #1;
      for (int i = 0; i < 8; i++) begin
        p = 7 - i;
        w = pattern ^ 8'(p * 17);
        exp[i*8 +: 8] = (i == 0 || i == 2 || i == 5 || i == 7) ? ~w : w;
      end
      chk64(logical_data, exp);
    end
  endtask
  task t_links;
    logic [7:0] code [5] = '{8'h0B, 8'h01, 8'h03, 8'h09, 8'h4B};
    logic [1:0] act [5] = '{2'h3, 2'h1, 2'h0, 2'h0, 2'h3};
    for (int i = 0; i < 5; i++) begin
      reg_wr(OFS_LINK_CONTROL, code[i]);
      repeat (2) @(posedge sys_clk);
      #1;
      chk8({6'h00, link_active}, {6'h00, act[i]});
    end
    @(posedge sys_clk);
    link1_rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    chk8({6'h00, link_active}, 8'h01);
  endtask
  // ==============================
  // Clock, watchdog, main sequence
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (3000) @(posedge sys_clk);
    error_cnt++;
    print_verdict;
  end
  initial begin
    reset_n = 1'b0;
    req = '0;
    fire = 1'b0;
    pll_on = 1'b0;
    pattern = 8'h00;
    link0_rst_n = 1'b1;
    link1_rst_n = 1'b1;
    error_cnt = 0;
    comparisons = 0;
    repeat (4) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_regs;
    t_pll;
    t_sync1;
    t_sync0;
    t_lanes;
    t_links;
    print_verdict;
  end
endmodule
